// *** hdl/csr_pkg.sv ***
/*
 Constants for the clock source routing configuration block: register
 offsets, field positions, reset values and encodings.
 Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
*/
// Behaviour
// - PLL power resets to async power-down
// - Power code 00 runs the PLL
// - Divider codes give 2..6, default /4
// - Select bit0 low uses divider path
// - Select bit0 high bypasses divider
// - Select bit1 chooses external or VCO
// - Control bit7 sets PFD polarity
// - Reset restores all routing defaults
// - Internal VCO off with external VCO
// - External oscillator feeds prescaler directly; here only with power code 00
// - Divider path divides by at least two
package csr_pkg;
   // ---------------------------------------------------------------
   // Register indices; the byte address is the index times four
   // ---------------------------------------------------------------
   localparam logic [11:0] CSR_IDX_PLL_CTRL = 12'h010;
   localparam logic [11:0] CSR_IDX_VCO_CAL = 12'h018;
   localparam logic [11:0] CSR_IDX_VCO_DIV = 12'h1E0;
   localparam logic [11:0] CSR_IDX_DIST_SEL = 12'h1E1;
   localparam logic [11:0] CSR_IDX_UPDATE = 12'h232;
   localparam logic [11:0] CSR_IDX_STATUS = 12'h300;
   localparam int CSR_ADDR_W = 14;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int CSR_PFD_POL_BIT = 7;
   localparam int CSR_BYPASS_BIT = 0;
   localparam int CSR_SRC_VCO_BIT = 1;
   localparam logic [1:0] CSR_PWR_RUN = 2'h0;
   localparam logic [1:0] CSR_PWR_ASYNC_PD = 2'h1;
   localparam logic [7:0] CSR_PLL_CTRL_RST = 8'h01;
   localparam logic [7:0] CSR_VCO_CAL_RST = 8'h00;
   localparam logic [7:0] CSR_VCO_DIV_RST = 8'h02;
   localparam logic [7:0] CSR_DIST_SEL_RST = 8'h00;
   // Divider codes 0..4 map to ratios 2..6
   localparam logic [2:0] CSR_DIV_MAX_CODE = 3'h4;
   localparam logic [2:0] CSR_DIV_BASE = 3'h2;
   localparam int CSR_CAL_CYCLES = 16;
endpackage : csr_pkg

// *** hdl/csr_div_map.sv ***
/*
 Maps the committed divider code to a divide ratio.
 Assumes the code comes from the committed register bank.
*/
module csr_div_map (
   // Code in
   input wire logic [2:0] code,
   // Ratio out
   output logic [2:0] ratio
);
   import csr_pkg::*;
   // code plus base gives 2..6; out-of-range clamps to two
   always_comb begin
      if (code <= CSR_DIV_MAX_CODE) begin
         ratio = code + CSR_DIV_BASE;
      end else begin
         ratio = CSR_DIV_BASE;
      end
   end
endmodule : csr_div_map

// *** hdl/csr_cal_seq.sv ***
/*
 VCO calibration sequencer: a committed rising calibration bit starts a
 fixed-length calibration run.
 Assumes the commit pulse is one cycle and follows register staging.
*/
module csr_cal_seq (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic cal_bit,
   input wire logic commit,
   // Status
   output logic cal_busy,
   output logic cal_done
);
   import csr_pkg::*;
   typedef enum logic [1:0] {CSR_ARMED, CSR_RUN, CSR_DONE} csr_cal_st_t;
   typedef struct packed {
      csr_cal_st_t st;
      logic [4:0] cnt;
      logic last;
   } csr_cal_t;
   csr_cal_t s_q, s_d;
   // start only on committed 0 to 1; first armed at reset
   always_comb begin
      s_d = s_q;
      if (commit) begin
         s_d.last = cal_bit;
      end
      case (s_q.st)
         CSR_ARMED: begin
            if (commit && cal_bit && !s_q.last) begin
               s_d.st = CSR_RUN;
               s_d.cnt = 5'(CSR_CAL_CYCLES - 1);
            end
         end
         CSR_RUN: begin
            if (s_q.cnt == 5'h00) begin
               s_d.st = CSR_DONE;
            end else begin
               s_d.cnt = s_q.cnt - 5'h01;
            end
         end
         CSR_DONE: begin
            if (commit && cal_bit && !s_q.last) begin
               s_d.st = CSR_RUN;
               s_d.cnt = 5'(CSR_CAL_CYCLES - 1);
            end
         end
         default: s_d.st = CSR_ARMED;
      endcase
   end
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{st: CSR_ARMED, cnt: 5'h00, last: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end
   assign cal_busy = (s_q.st == CSR_RUN);
   assign cal_done = (s_q.st == CSR_DONE);
   // Calibration run length check
   cal_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(cal_busy) |-> cal_busy [*8] ##1 cal_busy [*8] ##1 !cal_busy)
      else $error("calibration length wrong");
   cal_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (commit && cal_bit && !s_q.last && !cal_busy) |=> cal_busy)
      else $error("calibration did not start");
   cal_run_c: cover property (@(posedge hclk) disable iff (!hresetn)
      $fell(cal_busy));
endmodule : csr_cal_seq

// *** hdl/csr_top.sv ***
/*
 Clock source routing configuration: AHB-Lite register slave with staged
 and committed PLL power, PFD polarity, VCO divider and distribution
 select, plus calibration sequencing.
 Assumes a single AHB-Lite master, single word transfers, one clock.
*/
// Design decision made here: the AHB-Lite slave port.
module csr_top (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Analog controls
   output logic pll_pwr_down,
   output logic pll_run,
   output logic pfd_neg_pol,
   output logic int_vco_on,
   output logic ext_to_prescaler,
   output logic [2:0] vco_div_ratio,
   output logic dist_bypass_div,
   output logic dist_src_vco,
   output logic cal_busy
);
   import csr_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr_pend;
      logic [CSR_ADDR_W-1:0] wr_addr;
      logic [7:0] st_pll;
      logic [7:0] st_cal;
      logic [7:0] st_div;
      logic [7:0] st_dsel;
      logic [7:0] ac_pll;
      logic [7:0] ac_cal;
      logic [7:0] ac_div;
      logic [7:0] ac_dsel;
      logic commit;
      logic [31:0] rdata;
   } csr_state_t;
   csr_state_t s_q, s_d;
   logic cal_done;
   logic [2:0] ratio;

   // Word match helper, used for both read and write decode
   function automatic logic csr_hit(input logic [CSR_ADDR_W-1:0] a,
                                    input logic [11:0] idx);
      csr_hit = (a == {idx, 2'b00});
   endfunction : csr_hit

   // ---------------------------------------------------------------
   // Bus and register logic
   // ---------------------------------------------------------------
   logic take;
   logic [CSR_ADDR_W-1:0] a_in;
   assign take = hsel && hready && htrans[1];
   assign a_in = haddr[CSR_ADDR_W-1:0];

   // Staged writes land in data phase; reads are prepared at address phase
   always_comb begin
      s_d = s_q;
      s_d.commit = 1'b0;
      s_d.wr_pend = take && hwrite;
      if (take && hwrite) begin
         s_d.wr_addr = a_in;
      end
      if (s_q.wr_pend) begin
         if (csr_hit(s_q.wr_addr, CSR_IDX_PLL_CTRL)) begin
            s_d.st_pll = hwdata[7:0];
         end
         if (csr_hit(s_q.wr_addr, CSR_IDX_VCO_CAL)) begin
            s_d.st_cal = hwdata[7:0];
         end
         if (csr_hit(s_q.wr_addr, CSR_IDX_VCO_DIV)) begin
            s_d.st_div = hwdata[7:0];
         end
         if (csr_hit(s_q.wr_addr, CSR_IDX_DIST_SEL)) begin
            s_d.st_dsel = hwdata[7:0];
         end
         // update bit copies staged into active
         if (csr_hit(s_q.wr_addr, CSR_IDX_UPDATE) && hwdata[0]) begin
            s_d.ac_pll = s_q.st_pll;
            s_d.ac_cal = s_q.st_cal;
            s_d.ac_div = s_q.st_div;
            s_d.ac_dsel = s_q.st_dsel;
            s_d.commit = 1'b1;
         end
      end
      // Read data, unmapped reads as zero
      s_d.rdata = 32'h0000_0000;
      if (take && !hwrite) begin
         if (csr_hit(a_in, CSR_IDX_PLL_CTRL)) begin
            s_d.rdata = {24'h00_0000, s_q.st_pll};
         end else if (csr_hit(a_in, CSR_IDX_VCO_CAL)) begin
            s_d.rdata = {24'h00_0000, s_q.st_cal};
         end else if (csr_hit(a_in, CSR_IDX_VCO_DIV)) begin
            s_d.rdata = {24'h00_0000, s_q.st_div};
         end else if (csr_hit(a_in, CSR_IDX_DIST_SEL)) begin
            s_d.rdata = {24'h00_0000, s_q.st_dsel};
         end else if (csr_hit(a_in, CSR_IDX_STATUS)) begin
            s_d.rdata = {26'h000_0000, cal_done, cal_busy, s_q.ac_pll[1:0],
                         s_q.ac_dsel[1:0]};
         end
      end
   end

   // reset loads power-down, /4, divider path, external clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '{wr_pend: 1'b0, wr_addr: '0,
                  st_pll: CSR_PLL_CTRL_RST, st_cal: CSR_VCO_CAL_RST,
                  st_div: CSR_VCO_DIV_RST, st_dsel: CSR_DIST_SEL_RST,
                  ac_pll: CSR_PLL_CTRL_RST, ac_cal: CSR_VCO_CAL_RST,
                  ac_div: CSR_VCO_DIV_RST, ac_dsel: CSR_DIST_SEL_RST,
                  commit: 1'b0, rdata: 32'h0000_0000};
      end else begin
         s_q <= s_d;
      end
   end

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;

   // ---------------------------------------------------------------
   // Routing decode
   // ---------------------------------------------------------------
   // power code drives power-down and run
   assign pll_pwr_down = (s_q.ac_pll[1:0] == CSR_PWR_ASYNC_PD);
   assign pll_run = (s_q.ac_pll[1:0] == CSR_PWR_RUN);
   assign pfd_neg_pol = s_q.ac_pll[CSR_PFD_POL_BIT];
   assign dist_bypass_div = s_q.ac_dsel[CSR_BYPASS_BIT];
   assign dist_src_vco = s_q.ac_dsel[CSR_SRC_VCO_BIT];
   // internal VCO only powered when it is the source
   assign int_vco_on = dist_src_vco && pll_run;
   // external input routed straight to prescaler only while the PLL runs
   assign ext_to_prescaler = pll_run && !dist_src_vco;

   csr_div_map u_div (
      .code(s_q.ac_div[2:0]),
      .ratio(ratio)
   );
   assign vco_div_ratio = ratio;

   csr_cal_seq u_cal (
      .hclk(hclk),
      .hresetn(hresetn),
      .cal_bit(s_q.ac_cal[0]),
      .commit(s_q.commit),
      .cal_busy(cal_busy),
      .cal_done(cal_done)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   reset_default_a: assert property (@(posedge hclk)
      $rose(hresetn) |-> pll_pwr_down && vco_div_ratio == 3'h4 &&
      !dist_bypass_div && !dist_src_vco)
      else $error("reset defaults wrong");
   pwr_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pll_run |-> !pll_pwr_down)
      else $error("power decode wrong");
   div_min_a: assert property (@(posedge hclk) disable iff (!hresetn)
      vco_div_ratio >= 3'h2 && vco_div_ratio <= 3'h6)
      else $error("divider ratio out of range");
   staged_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_q.commit |-> $stable(s_q.ac_dsel) && $stable(s_q.ac_pll))
      else $error("active changed without update");
   commit_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
      s_q.commit |-> s_q.ac_dsel == $past(s_q.st_dsel))
      else $error("update copy wrong");
   ext_vco_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ext_to_prescaler |-> !int_vco_on)
      else $error("internal vco on with external");
   ext_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (pll_run && !dist_src_vco) |-> ext_to_prescaler)
      else $error("external not routed");
   pol_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pfd_neg_pol == s_q.ac_pll[7])
      else $error("polarity wrong");
   bypass_c: cover property (@(posedge hclk) disable iff (!hresetn)
      dist_bypass_div);
   vco_src_c: cover property (@(posedge hclk) disable iff (!hresetn)
      dist_src_vco && pll_run);
   read_c: cover property (@(posedge hclk) disable iff (!hresetn)
      take && !hwrite ##1 hrdata != 32'h0000_0000);
endmodule : csr_top

// *** sim/csr_testbench.sv ***
/*
 Self-checking bench for the clock source routing block: AHB-Lite single
 word transfers, staged fields, commit, divider codes, calibration, reset.
 Assumes csr_pkg and csr_top are compiled first; zero-wait slave.
*/
`define CMP(nm, e, s) \
   n_tests++; \
   if ((s) !== (e)) begin \
      num_errors++; \
      $display("wrong value %s exp %h got %h", nm, e, s); \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import csr_pkg::*;
   // -----------------------------------------------------------------
   // Signals
   // -----------------------------------------------------------------
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rb;
   logic [1:0] htrans;
   logic [2:0] hsize, vco_div_ratio;
   logic pll_pwr_down, pll_run, pfd_neg_pol, int_vco_on, ext_to_prescaler;
   logic dist_bypass_div, dist_src_vco, cal_busy, rd_dp, pc, p;
   logic [10:0] pv, ep;
   logic [31:0] er;
   logic [31:0] rq[$];
   logic [10:0] pq[$];
   int num_errors = 0;
   int n_tests = 0;
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   assign pv = {cal_busy, dist_src_vco, dist_bypass_div, vco_div_ratio,
                ext_to_prescaler, int_vco_on, pfd_neg_pol, pll_run,
                pll_pwr_down};
   csr_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pll_pwr_down(pll_pwr_down),
      .pll_run(pll_run), .pfd_neg_pol(pfd_neg_pol), .int_vco_on(int_vco_on),
      .ext_to_prescaler(ext_to_prescaler), .vco_div_ratio(vco_div_ratio),
      .dist_bypass_div(dist_bypass_div), .dist_src_vco(dist_src_vco),
      .cal_busy(cal_busy));
   // -----------------------------------------------------------------
   // Expectations and bus tasks
   // -----------------------------------------------------------------
   // Expected port vector worked out from the field values
   function automatic logic [10:0] ev(input logic [1:0] pw, input logic pol,
         input logic [2:0] dc, input logic [1:0] ds, input logic bz);
      logic run;
      logic [2:0] r;
      run = (pw == 2'h0);
      r = (dc <= 3'h4) ? dc + 3'h2 : 3'h2;
      return {bz, ds[1], ds[0], r, run & ~ds[1], run & ds[1], pol, run,
              pw == 2'h1};
   endfunction : ev
   // Register index to byte address: indices are not all word multiples
   function automatic logic [31:0] ba(input logic [11:0] i);
      return {18'h0, i, 2'h0};
   endfunction : ba
   // Called just after a rising edge; holds each phase until hready
   task automatic xf(input logic w, input logic [11:0] i,
         input logic [31:0] d, input logic [31:0] e);
      hsel <= 1'b1;
      haddr <= ba(i);
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      if (!w) begin
         rq.push_back(e);
         rd_dp <= 1'b1;
      end
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd_dp <= 1'b0;
   endtask : xf
   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      xf(1'b1, i, d, 32'h0);
   endtask : wr
   task automatic rd(input logic [11:0] i, input logic [31:0] e);
      xf(1'b0, i, 32'h0, e);
   endtask : rd
   // Commit, then let the active copies reach the outputs
   task automatic upd();
      wr(CSR_IDX_UPDATE, 32'h1);
      @(posedge hclk);
   endtask : upd
   task automatic chk(input logic [10:0] e);
      pq.push_back(e);
      pc <= 1'b1;
      @(posedge hclk);
      pc <= 1'b0;
   endtask : chk
   task automatic end_sim();
      $display("tests %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   // -----------------------------------------------------------------
   // Clock, monitor, watchdog
   // -----------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Oldest note is compared when a read or port result is due
   always @(posedge hclk) begin
      if (rd_dp) begin
         er = rq.pop_front();
         `CMP("read data", er, hrdata)
         `CMP("response", 1'b0, hresp)
      end
      if (pc) begin
         ep = pq.pop_front();
         `CMP("port state", ep, pv)
      end
   end
   // Whole run is about 130 cycles; this is far past it
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      {hresetn, hsel, hwrite, rd_dp, pc} = 5'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      void'($urandom(32'h3445d6fd));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk(ev(2'h1, 1'b0, 3'h2, 2'h0, 1'b0));
      rd(CSR_IDX_PLL_CTRL, {24'h0, CSR_PLL_CTRL_RST});
      rd(CSR_IDX_VCO_DIV, {24'h0, CSR_VCO_DIV_RST});
      rd(CSR_IDX_DIST_SEL, {24'h0, CSR_DIST_SEL_RST});
      rd(12'h100, 32'h0);
      $display("test defaults done");
      // Staged values must not reach the outputs before the commit
      rb = $urandom;
      p = rb[0];
      wr(CSR_IDX_PLL_CTRL, {rb[31:8], p, 7'h0});
      wr(CSR_IDX_DIST_SEL, {rb[31:8], 8'h03});
      chk(ev(2'h1, 1'b0, 3'h2, 2'h0, 1'b0));
      rd(CSR_IDX_PLL_CTRL, {24'h0, p, 7'h0});
      upd();
      chk(ev(2'h0, p, 3'h2, 2'h3, 1'b0));
      wr(CSR_IDX_DIST_SEL, 32'h1);
      upd();
      chk(ev(2'h0, p, 3'h2, 2'h1, 1'b0));
      $display("test staging done");
      // Every divider code, including the out-of-range ones
      wr(CSR_IDX_DIST_SEL, 32'h0);
      for (int c = 0; c < 8; c++) begin
         rb = $urandom;
         wr(CSR_IDX_VCO_DIV, {rb[31:8], 5'h00, 3'(c)});
         upd();
         chk(ev(2'h0, p, 3'(c), 2'h0, 1'b0));
      end
      $display("test divider done");
      // First calibration skips the clear; the second one clears first
      wr(CSR_IDX_VCO_CAL, 32'h1);
      upd();
      chk(ev(2'h0, p, 3'h7, 2'h0, 1'b1));
      repeat (CSR_CAL_CYCLES + 4) @(posedge hclk);
      chk(ev(2'h0, p, 3'h7, 2'h0, 1'b0));
      rd(CSR_IDX_STATUS, 32'h0000_0020);
      wr(CSR_IDX_VCO_CAL, 32'h0);
      upd();
      wr(CSR_IDX_VCO_CAL, 32'h1);
      upd();
      chk(ev(2'h0, p, 3'h7, 2'h0, 1'b1));
      $display("test calibration done");
      // Reset in mid-run restores every default
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      chk(ev(2'h1, 1'b0, 3'h2, 2'h0, 1'b0));
      rd(CSR_IDX_PLL_CTRL, {24'h0, CSR_PLL_CTRL_RST});
      rd(CSR_IDX_DIST_SEL, {24'h0, CSR_DIST_SEL_RST});
      rd(CSR_IDX_VCO_DIV, {24'h0, CSR_VCO_DIV_RST});
      $display("test reset done");
      repeat (2) @(posedge hclk);
      end_sim();
   end
endmodule : testbench
